// [hw/amd_decoder.sv]
// addressing mode decoder: length, effective address, branch target
//
// Summary of operation
// - inherent instructions are one byte, two with prebyte 90
// - inherent set has sleep and halt requests
// - immediate is opcode plus one operand byte
// - direct short uses one byte, page zero
// - direct long uses two-byte 16-bit address
// - indexed address is unsigned index plus offset
// - no-offset indexed uses index alone, no byte
// - short indexed offset byte, reach 1FE
// - long indexed word offset, full space
// - indirect reads pointer at following address
// - short indirect one-byte pointer, page zero
// - long indirect reads word pointer, one byte
// - indirect indexed adds index to pointer
// - short indirect indexed reaches 1FE
// - full group accepts short and long forms
// - short group accepts short forms only
// - relative adds signed byte to counter
// - only relative jumps and call use relative
// - relative offset inline or read from memory
// - prebyte 90 swaps X for Y
// - prebyte 92 turns direct into indirect
// - prebyte 91 gives Y indirect indexed
// - counter points past the jump instruction
`timescale 1ns/100ps
`default_nettype none
`include "amd_consts.svh"

module amd_decoder
    import amd_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_valid_i,
    input  wire amd_req_s    req_i,
    input  wire logic [7:0]  idx_x_i,
    input  wire logic [7:0]  idx_y_i,
    output logic             ready_o,
    output logic             mem_req_o,
    output logic [15:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             done_o,
    output amd_res_s         res_o,
    output logic             sleep_req_o,
    output logic             halt_req_o
);

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    amd_mode_e  eff_m;
    logic       eff_y;
    logic       pre_bad;
    logic       grp_bad;
    logic [2:0] ext;
    logic [2:0] len_d;
    logic       is_long;
    logic       is_rel;

    always_comb begin
        eff_m   = req_i.mode;
        eff_y   = 1'b0;
        pre_bad = 1'b0;
        if (req_i.has_pre) begin
            if (req_i.pre == `AMD_PRE_Y) begin
                case (req_i.mode)
                    AMD_M_INH, AMD_M_IMM, AMD_M_DIR_S,
                    AMD_M_DIR_L, AMD_M_IDX0, AMD_M_IDX_S,
                    AMD_M_IDX_L: eff_y = 1'b1;
                    default: pre_bad = 1'b1;
                endcase
            end else if (req_i.pre == `AMD_PRE_IND) begin
                case (req_i.mode)
                    AMD_M_DIR_S: eff_m = AMD_M_IND_S;
                    AMD_M_DIR_L: eff_m = AMD_M_IND_L;
                    AMD_M_IDX_S: eff_m = AMD_M_IIX_S;
                    AMD_M_IDX_L: eff_m = AMD_M_IIX_L;
                    AMD_M_REL_D: eff_m = AMD_M_REL_I;
                    default: pre_bad = 1'b1;
                endcase
            end else if (req_i.pre == `AMD_PRE_IY) begin
                case (req_i.mode)
                    AMD_M_IDX_S, AMD_M_IIX_S: begin
                        eff_m = AMD_M_IIX_S;
                        eff_y = 1'b1;
                    end
                    AMD_M_IDX_L, AMD_M_IIX_L: begin
                        eff_m = AMD_M_IIX_L;
                        eff_y = 1'b1;
                    end
                    default: pre_bad = 1'b1;
                endcase
            end else begin
                pre_bad = 1'b1;
            end
        end
    end

    // bytes that follow the opcode
    always_comb begin
        case (eff_m)
            AMD_M_INH:   ext = `AMD_EXT_NONE;
            AMD_M_IDX0:  ext = `AMD_EXT_NONE;
            AMD_M_IMM:   ext = `AMD_EXT_ONE;
            AMD_M_DIR_S: ext = `AMD_EXT_ONE;
            AMD_M_DIR_L: ext = `AMD_EXT_TWO;
            AMD_M_IDX_S: ext = `AMD_EXT_ONE;
            AMD_M_IDX_L: ext = `AMD_EXT_TWO;
            AMD_M_IND_S: ext = `AMD_EXT_ONE;
            AMD_M_IND_L: ext = `AMD_EXT_ONE;
            AMD_M_IIX_S: ext = `AMD_EXT_ONE;
            AMD_M_IIX_L: ext = `AMD_EXT_ONE;
            AMD_M_REL_D: ext = `AMD_EXT_ONE;
            AMD_M_REL_I: ext = `AMD_EXT_ONE;
            default:     ext = `AMD_EXT_NONE;
        endcase
    end

    assign len_d = `AMD_LEN_OPC + ext
                 + (req_i.has_pre ? `AMD_LEN_PRE : `AMD_EXT_NONE);

    assign is_long = (eff_m == AMD_M_DIR_L) || (eff_m == AMD_M_IDX_L)
                  || (eff_m == AMD_M_IND_L) || (eff_m == AMD_M_IIX_L);
    assign is_rel  = (eff_m == AMD_M_REL_D) || (eff_m == AMD_M_REL_I);

    // group check; no-memory ops take inherent or immediate only
    always_comb begin
        grp_bad = 1'b0;
        case (req_i.grp)
            AMD_G_FULL:  grp_bad = is_rel;
            AMD_G_SHORT: grp_bad = is_rel || is_long
                                || (eff_m == AMD_M_IMM);
            AMD_G_REL:   grp_bad = !is_rel;
            AMD_G_NOMEM: grp_bad = !((eff_m == AMD_M_INH)
                                || (eff_m == AMD_M_IMM));
            default:     grp_bad = 1'b1;
        endcase
    end

    // ----------------------------------------
    // latched request
    // ----------------------------------------
    amd_state_e  st_q;
    amd_mode_e   m_q;
    amd_inh_e    inh_q;
    logic        y_q;
    logic        ill_q;
    logic [2:0]  len_q;
    logic [7:0]  b1_q;
    logic [7:0]  b2_q;
    logic [7:0]  idx_q;
    logic [15:0] pcn_q;
    logic [7:0]  hi_q;
    logic [7:0]  lo_q;
    logic        take;

    // one instruction at a time; no queue, so fetch must wait
    assign ready_o = (st_q == AMD_S_IDLE);
    assign take    = req_valid_i && ready_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_q   <= AMD_M_INH;
            inh_q <= AMD_I_OTHER;
            y_q   <= 1'b0;
            ill_q <= 1'b0;
            len_q <= `AMD_LEN_OPC;
            b1_q  <= `AMD_RST_BYTE;
            b2_q  <= `AMD_RST_BYTE;
            idx_q <= `AMD_RST_BYTE;
            pcn_q <= `AMD_RST_ADDR;
        end else if (take) begin
            m_q   <= eff_m;
            inh_q <= req_i.inh;
            y_q   <= eff_y;
            ill_q <= pre_bad || grp_bad;
            len_q <= len_d;
            b1_q  <= req_i.b1;
            b2_q  <= req_i.b2;
            // index sampled once, so later writes cannot move the address
            idx_q <= eff_y ? idx_y_i : idx_x_i;
            // counter already past this instruction
            pcn_q <= req_i.pc + {13'h0000, len_d};
        end
    end

    // ----------------------------------------
    // pointer fetch sequence
    // ----------------------------------------
    logic rd_need;
    logic rd_two;

    assign rd_need = (m_q == AMD_M_IND_S) || (m_q == AMD_M_IND_L)
                  || (m_q == AMD_M_IIX_S) || (m_q == AMD_M_IIX_L)
                  || (m_q == AMD_M_REL_I);
    assign rd_two  = (m_q == AMD_M_IND_L)
                  || (m_q == AMD_M_IIX_L);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= AMD_S_IDLE;
        end else begin
            case (st_q)
                AMD_S_IDLE: begin
                    if (take) begin
                        st_q <= AMD_S_RD0;
                    end
                end
                AMD_S_RD0: begin
                    // illegal forms never touch memory
                    if (ill_q || !rd_need) begin
                        st_q <= AMD_S_DONE;
                    end else if (mem_ack_i) begin
                        st_q <= rd_two ? AMD_S_RD1 : AMD_S_DONE;
                    end
                end
                AMD_S_RD1: begin
                    if (mem_ack_i) begin
                        st_q <= AMD_S_DONE;
                    end
                end
                AMD_S_DONE: begin
                    st_q <= AMD_S_IDLE;
                end
                default: begin
                    st_q <= AMD_S_IDLE;
                end
            endcase
        end
    end

    assign mem_req_o = ((st_q == AMD_S_RD0) && rd_need && !ill_q)
                    || (st_q == AMD_S_RD1);

    // pointer sits in page zero at the byte after the opcode
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_addr_o <= `AMD_RST_ADDR;
        end else if (take) begin
            mem_addr_o <= {`AMD_PAGE0, req_i.b1};
        end else if ((st_q == AMD_S_RD0) && mem_ack_i) begin
            // word pointer: second byte follows, high first
            mem_addr_o <= mem_addr_o + 16'h0001;
        end
    end

    // cleared per request so a byte pointer has a zero high half
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_q <= `AMD_RST_BYTE;
            lo_q <= `AMD_RST_BYTE;
        end else if (take) begin
            hi_q <= `AMD_RST_BYTE;
            lo_q <= `AMD_RST_BYTE;
        end else if ((st_q == AMD_S_RD0) && mem_ack_i) begin
            if (rd_two) begin
                hi_q <= mem_rdata_i;
            end else begin
                lo_q <= mem_rdata_i;
            end
        end else if ((st_q == AMD_S_RD1) && mem_ack_i) begin
            lo_q <= mem_rdata_i;
        end
    end

    // ----------------------------------------
    // address and target forming
    // ----------------------------------------
    logic [15:0] ix16;
    logic [15:0] ptr16;
    logic [15:0] ea_d;
    logic [7:0]  off;
    logic [15:0] tgt_d;

    assign ix16  = {`AMD_PAGE0, idx_q};
    assign ptr16 = {hi_q, lo_q};

    always_comb begin
        case (m_q)
            AMD_M_DIR_S: ea_d = {`AMD_PAGE0, b1_q};
            AMD_M_DIR_L: ea_d = {b1_q, b2_q};
            AMD_M_IDX0:  ea_d = ix16;
            // short sums keep their carry into bit 8
            AMD_M_IDX_S: ea_d = ix16 + {`AMD_PAGE0, b1_q};
            AMD_M_IDX_L: ea_d = ix16 + {b1_q, b2_q};
            AMD_M_IND_S: ea_d = ptr16;
            AMD_M_IND_L: ea_d = ptr16;
            AMD_M_IIX_S: ea_d = ix16 + ptr16;
            AMD_M_IIX_L: ea_d = ix16 + ptr16;
            default:     ea_d = `AMD_RST_ADDR;
        endcase
    end

    // offset inline or read from memory
    assign off   = (m_q == AMD_M_REL_I) ? lo_q : b1_q;
    // reach is 128 back, 127 forward
    assign tgt_d = pcn_q + {{8{off[7]}}, off};

    // ----------------------------------------
    // result and low power requests
    // ----------------------------------------
    logic fin;

    // result holds until the next done, so a slow consumer may read late
    assign fin = (st_q == AMD_S_DONE);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_o <= '0;
        end else if (fin) begin
            res_o.len     <= len_q;
            res_o.illegal <= ill_q;
            res_o.use_y   <= y_q;
            res_o.mode    <= m_q;
            res_o.imm     <= b1_q;
            res_o.ea      <= ea_d;
            res_o.target  <= tgt_d;
            res_o.is_rel  <= (m_q == AMD_M_REL_D)
                          || (m_q == AMD_M_REL_I);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o      <= 1'b0;
            sleep_req_o <= 1'b0;
            halt_req_o  <= 1'b0;
        end else begin
            done_o      <= fin;
            sleep_req_o <= fin && !ill_q && (m_q == AMD_M_INH)
                        && (inh_q == AMD_I_SLEEP);
            halt_req_o  <= fin && !ill_q && (m_q == AMD_M_INH)
                        && (inh_q == AMD_I_HALT);
        end
    end

endmodule
`default_nettype wire

// [hw/amd_consts.svh]
// constants for the addressing mode decoder
`ifndef AMD_CONSTS_SVH
`define AMD_CONSTS_SVH

// prebyte codes
`define AMD_PRE_Y      8'h90
`define AMD_PRE_IY     8'h91
`define AMD_PRE_IND    8'h92

// bytes after the opcode
`define AMD_EXT_NONE   3'h0
`define AMD_EXT_ONE    3'h1
`define AMD_EXT_TWO    3'h2

// opcode byte and prebyte each count one
`define AMD_LEN_OPC    3'h1
`define AMD_LEN_PRE    3'h1

// page zero high byte
`define AMD_PAGE0      8'h00
`define AMD_RST_ADDR   16'h0000
`define AMD_RST_BYTE   8'h00

`endif

// [hw/amd_pkg.sv]
// types for the addressing mode decoder
`default_nettype none
package amd_pkg;

    typedef enum logic [3:0] {
        AMD_M_INH   = 4'b0000,
        AMD_M_IMM   = 4'b0001,
        AMD_M_DIR_S = 4'b0010,
        AMD_M_DIR_L = 4'b0011,
        AMD_M_IDX0  = 4'b0100,
        AMD_M_IDX_S = 4'b0101,
        AMD_M_IDX_L = 4'b0110,
        AMD_M_IND_S = 4'b0111,
        AMD_M_IND_L = 4'b1000,
        AMD_M_IIX_S = 4'b1001,
        AMD_M_IIX_L = 4'b1010,
        AMD_M_REL_D = 4'b1011,
        AMD_M_REL_I = 4'b1100
    } amd_mode_e;

    // operation groups by accepted modes
    typedef enum logic [1:0] {
        AMD_G_FULL  = 2'b00,
        AMD_G_SHORT = 2'b01,
        AMD_G_REL   = 2'b10,
        AMD_G_NOMEM = 2'b11
    } amd_grp_e;

    typedef enum logic [1:0] {
        AMD_I_OTHER = 2'b00,
        AMD_I_TRAP  = 2'b01,
        AMD_I_SLEEP = 2'b10,
        AMD_I_HALT  = 2'b11
    } amd_inh_e;

    typedef enum logic [1:0] {
        AMD_S_IDLE = 2'b00,
        AMD_S_RD0  = 2'b01,
        AMD_S_RD1  = 2'b10,
        AMD_S_DONE = 2'b11
    } amd_state_e;

    typedef struct packed {
        logic       has_pre;
        logic [7:0] pre;
        amd_mode_e  mode;
        amd_grp_e   grp;
        amd_inh_e   inh;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [15:0] pc;
    } amd_req_s;

    typedef struct packed {
        logic [2:0]  len;
        logic        illegal;
        logic        use_y;
        amd_mode_e   mode;
        logic [7:0]  imm;
        logic [15:0] ea;
        logic [15:0] target;
        logic        is_rel;
    } amd_res_s;

endpackage
`default_nettype wire

// [bench/amd_decoder_chk.sv]
// assertion checker for the addressing mode decoder ports
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_chk
    import amd_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        req_valid_i,
    input wire amd_req_s    req_i,
    input wire logic [7:0]  idx_x_i,
    input wire logic [7:0]  idx_y_i,
    input wire logic        ready_o,
    input wire logic        mem_req_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        done_o,
    input wire amd_res_s    res_o,
    input wire logic        sleep_req_o,
    input wire logic        halt_req_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    logic        take;
    logic        plain;
    logic [7:0]  b1_q;
    logic [7:0]  x_q;
    logic [15:0] tgt_q;

    assign take  = req_valid_i && ready_o;
    assign plain = take && !req_i.has_pre;

    // ----------------------------------------
    // request values held from the take edge
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            b1_q  <= 8'h00;
            x_q   <= 8'h00;
            tgt_q <= 16'h0000;
        end else if (take) begin
            b1_q  <= req_i.b1;
            x_q   <= idx_x_i;
            tgt_q <= req_i.pc + 16'h0002 + {{8{req_i.b1[7]}}, req_i.b1};
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    // no memory read: answer on the third edge
    sequence s_quick;
        (!mem_req_o && !done_o) [*2] ##1 done_o;
    endsequence

    property p_inh_len;
        plain && req_i.mode == AMD_M_INH && req_i.grp == AMD_G_NOMEM
            |=> s_quick ##0 (res_o.len == 3'h1 && !res_o.illegal);
    endproperty
    a_inh_len: assert property (p_inh_len)
        else $error("inherent length not one");

    property p_imm;
        plain && req_i.mode == AMD_M_IMM && req_i.grp == AMD_G_FULL
            |=> s_quick ##0 (res_o.len == 3'h2 && res_o.imm == b1_q);
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate operand wrong");

    property p_dir_s;
        plain && req_i.mode == AMD_M_DIR_S && req_i.grp == AMD_G_FULL
            |=> s_quick ##0 (res_o.ea == {8'h00, b1_q} && res_o.len == 3'h2);
    endproperty
    a_dir_s: assert property (p_dir_s)
        else $error("direct short address wrong");

    property p_idx0;
        plain && req_i.mode == AMD_M_IDX0 && req_i.grp == AMD_G_SHORT
            |=> s_quick ##0 (res_o.ea == {8'h00, x_q} && res_o.len == 3'h1);
    endproperty
    a_idx0: assert property (p_idx0)
        else $error("no offset index address wrong");

    property p_rel;
        plain && req_i.mode == AMD_M_REL_D && req_i.grp == AMD_G_REL
            |=> s_quick ##0 (res_o.target == tgt_q && res_o.is_rel);
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative target wrong");

    property p_mem_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("read dropped or address moved");

    property p_ptr_page0;
        $rose(mem_req_o) |-> mem_addr_o[15:8] == 8'h00;
    endproperty
    a_ptr_page0: assert property (p_ptr_page0)
        else $error("pointer address outside page zero");

    // second pointer byte follows the first
    sequence s_next_rd;
        mem_req_o && mem_ack_i ##1 mem_req_o;
    endsequence
    property p_word_next;
        s_next_rd |-> mem_addr_o == $past(mem_addr_o) + 16'h0001;
    endproperty
    a_word_next: assert property (p_word_next)
        else $error("second pointer byte address wrong");

    property p_sleep;
        sleep_req_o |-> done_o && !res_o.illegal && res_o.mode == AMD_M_INH;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep request without legal inherent");

    property p_halt;
        halt_req_o |-> done_o && !sleep_req_o && !res_o.illegal
            && res_o.mode == AMD_M_INH;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt request without legal inherent");
endmodule
`default_nettype wire

// [bench/amd_decoder_tb.sv]
// self-checking bench for the addressing mode decoder
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_tb
    import amd_pkg::*;
();
    typedef struct packed {
        logic [7:0]  pre;
        amd_mode_e   mode;
        amd_grp_e    grp;
        logic [7:0]  b1;
        logic [3:0]  lx;    // illegal flag over total length
        amd_mode_e   emode;
        logic [15:0] ad;    // ea, target or immediate
    } amd_row_s;

    logic        clk_sys_i;
    logic        rst_n_i;
    logic        req_valid_i;
    amd_req_s    req_i;
    logic [7:0]  idx_x_i;
    logic [7:0]  idx_y_i;
    logic        ready_o;
    logic        mem_req_o;
    logic [15:0] mem_addr_o;
    logic        mem_ack_i = 1'b0;
    logic [7:0]  mem_rdata_i = 8'h00;
    logic        done_o;
    amd_res_s    res_o;
    logic        sleep_req_o;
    logic        halt_req_o;
    int          err_count = 0;
    int          checks = 0;
    int          lat = 0;
    int          wt_m = 0;
    int          cyc = 0;

    // x = ff, y = 01, pc = 1000, b2 = 34, memory byte = address + 30
    amd_row_s rows [30] = '{
    '{8'h00, AMD_M_INH, AMD_G_NOMEM, 8'h02, 4'h1, AMD_M_INH, 16'h0000},
    '{8'h90, AMD_M_INH, AMD_G_NOMEM, 8'h03, 4'h2, AMD_M_INH, 16'h0000},
    '{8'h00, AMD_M_IMM, AMD_G_FULL, 8'h55, 4'h2, AMD_M_IMM, 16'h0055},
    '{8'h00, AMD_M_DIR_S, AMD_G_FULL, 8'h80, 4'h2, AMD_M_DIR_S, 16'h0080},
    '{8'h00, AMD_M_DIR_L, AMD_G_FULL, 8'h12, 4'h3, AMD_M_DIR_L, 16'h1234},
    '{8'h00, AMD_M_IDX0, AMD_G_SHORT, 8'h00, 4'h1, AMD_M_IDX0, 16'h00FF},
    '{8'h90, AMD_M_IDX0, AMD_G_SHORT, 8'h00, 4'h2, AMD_M_IDX0, 16'h0001},
    '{8'h00, AMD_M_IDX_S, AMD_G_FULL, 8'hFF, 4'h2, AMD_M_IDX_S, 16'h01FE},
    '{8'h00, AMD_M_IDX_L, AMD_G_FULL, 8'hFF, 4'h3, AMD_M_IDX_L, 16'h0033},
    '{8'h92, AMD_M_DIR_S, AMD_G_SHORT, 8'h20, 4'h3, AMD_M_IND_S, 16'h0050},
    '{8'h92, AMD_M_DIR_L, AMD_G_FULL, 8'h20, 4'h3, AMD_M_IND_L, 16'h5051},
    '{8'h92, AMD_M_IDX_S, AMD_G_SHORT, 8'h20, 4'h3, AMD_M_IIX_S, 16'h014F},
    '{8'h91, AMD_M_IDX_L, AMD_G_FULL, 8'h20, 4'h3, AMD_M_IIX_L, 16'h5052},
    '{8'h00, AMD_M_REL_D, AMD_G_REL, 8'hFE, 4'h2, AMD_M_REL_D, 16'h1000},
    '{8'h00, AMD_M_REL_D, AMD_G_REL, 8'h80, 4'h2, AMD_M_REL_D, 16'h0F82},
    '{8'h92, AMD_M_REL_D, AMD_G_REL, 8'h20, 4'h3, AMD_M_REL_I, 16'h1053},
    '{8'h00, AMD_M_IMM, AMD_G_SHORT, 8'h00, 4'hA, AMD_M_IMM, 16'h0000},
    '{8'h00, AMD_M_DIR_L, AMD_G_SHORT, 8'h12, 4'hB, AMD_M_DIR_L, 16'h0000},
    '{8'h93, AMD_M_DIR_S, AMD_G_FULL, 8'h10, 4'hB, AMD_M_DIR_S, 16'h0000},
    '{8'h00, AMD_M_INH, AMD_G_NOMEM, 8'h01, 4'h1, AMD_M_INH, 16'h0000},
    '{8'h92, AMD_M_INH, AMD_G_NOMEM, 8'h02, 4'hA, AMD_M_INH, 16'h0000},
    '{8'h90, AMD_M_DIR_L, AMD_G_FULL, 8'h12, 4'h4, AMD_M_DIR_L, 16'h1234},
    '{8'h90, AMD_M_IDX_S, AMD_G_FULL, 8'h10, 4'h3, AMD_M_IDX_S, 16'h0011},
    '{8'h92, AMD_M_IDX_L, AMD_G_FULL, 8'h20, 4'h3, AMD_M_IIX_L, 16'h5150},
    '{8'h91, AMD_M_IDX_S, AMD_G_SHORT, 8'h20, 4'h3, AMD_M_IIX_S, 16'h0051},
    '{8'h90, AMD_M_REL_D, AMD_G_REL, 8'h10, 4'hB, AMD_M_REL_D, 16'h0000},
    '{8'h00, AMD_M_DIR_S, AMD_G_REL, 8'h10, 4'hA, AMD_M_DIR_S, 16'h0000},
    '{8'h00, AMD_M_REL_D, AMD_G_FULL, 8'h10, 4'hA, AMD_M_REL_D, 16'h0000},
    '{8'h91, AMD_M_DIR_S, AMD_G_FULL, 8'h10, 4'hB, AMD_M_DIR_S, 16'h0000},
    '{8'h00, AMD_M_DIR_S, AMD_G_NOMEM, 8'h10, 4'hA, AMD_M_DIR_S, 16'h0000}
    };

    amd_decoder i_amd_decoder (
        .clk_sys_i, .rst_n_i, .req_valid_i, .req_i, .idx_x_i, .idx_y_i,
        .ready_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i,
        .done_o, .res_o, .sleep_req_o, .halt_req_o
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ----------------------------------------
    // memory side: answers after lat cycles
    // ----------------------------------------
    // idle data toggles so a stale byte never looks right
    always @(negedge clk_sys_i) begin
        if (mem_req_o === 1'b1 && !mem_ack_i && wt_m >= lat) begin
            mem_ack_i   <= 1'b1;
            mem_rdata_i <= mem_addr_o[7:0] + 8'h30;
            wt_m        <= 0;
        end else begin
            mem_ack_i   <= 1'b0;
            mem_rdata_i <= ~mem_rdata_i;
            wt_m        <= (mem_req_o === 1'b1 && !mem_ack_i) ? wt_m + 1 : 0;
        end
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic send(input amd_row_s r);
        @(negedge clk_sys_i);
        req_i = '{has_pre: r.pre != 8'h00, pre: r.pre, mode: r.mode,
                  grp: r.grp, b1: r.b1, b2: 8'h34, pc: 16'h1000,
                  inh: (r.mode == AMD_M_INH) ? amd_inh_e'(r.b1[1:0])
                                            : AMD_I_OTHER};
        req_valid_i = 1'b1;
        for (int n = 0; n < 50 && ready_o !== 1'b1; n++) begin
            @(negedge clk_sys_i);
        end
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
    endtask

    task automatic run_row(input amd_row_s r);
        logic [15:0] ad;
        logic        rel;
        logic        ok;
        send(r);
        for (int n = 0; n < 60 && done_o !== 1'b1; n++) begin
            @(negedge clk_sys_i);
        end
        chk("done", 16'h0001, 16'(done_o));
        chk("ready at done", 16'h0001, 16'(ready_o));
        rel = r.emode inside {AMD_M_REL_D, AMD_M_REL_I};
        ok  = !r.lx[3] && r.mode == AMD_M_INH;
        ad  = rel ? res_o.target : res_o.ea;
        if (r.emode == AMD_M_IMM) begin
            ad = {8'h00, res_o.imm};
        end
        chk("length", 16'(r.lx[2:0]), 16'(res_o.len));
        chk("illegal", 16'(r.lx[3]), 16'(res_o.illegal));
        chk("sleep", 16'(ok && r.b1 == 8'h02), 16'(sleep_req_o));
        chk("halt", 16'(ok && r.b1 == 8'h03), 16'(halt_req_o));
        if (!r.lx[3]) begin
            chk("use y", 16'(r.pre == 8'h90 || r.pre == 8'h91),
                16'(res_o.use_y));
            chk("mode", 16'(r.emode), 16'(res_o.mode));
            chk("address", r.ad, ad);
            chk("relative", 16'(rel), 16'(res_o.is_rel));
        end
    endtask

    task automatic test_done;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n_i     = 1'b0;
        req_valid_i = 1'b0;
        req_i       = '0;
        idx_x_i     = 8'hFF;
        idx_y_i     = 8'h01;
        repeat (5) @(negedge clk_sys_i);
        chk("ready in reset", 16'h0001, 16'(ready_o));
        chk("outputs in reset", 16'h0000, mem_addr_o |
            16'({mem_req_o, done_o, sleep_req_o, halt_req_o, |res_o}));
        rst_n_i = 1'b1;
        // prompt memory first, then a slow one
        for (int l = 0; l < 2; l++) begin
            lat = 3 * l;
            foreach (rows[i]) begin
                run_row(rows[i]);
            end
        end
        // reset while a pointer read is stalled
        lat = 40;
        send(rows[10]);
        repeat (4) @(negedge clk_sys_i);
        chk("read pending", 16'h0001, 16'(mem_req_o));
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        chk("ready after abort", 16'h0001, 16'(ready_o));
        chk("read after abort", 16'h0000, 16'(mem_req_o));
        rst_n_i = 1'b1;
        lat = 0;
        run_row(rows[12]);
        test_done();
    end
endmodule

bind amd_decoder amd_decoder_chk i_amd_decoder_chk (
    .clk_sys_i, .rst_n_i, .req_valid_i, .req_i, .idx_x_i, .idx_y_i,
    .ready_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i,
    .done_o, .res_o, .sleep_req_o, .halt_req_o
);
`default_nettype wire
